// ### include/hdlc_tx_pkg.sv
// Shared types and constants of the serial async/HDLC transmitter
package hdlc_tx_pkg;

  // Fixed line patterns, as sent least significant bit first
  localparam logic [7:0]  FLAG_BYTE  = 8'h7e;
  localparam logic [7:0]  ABORT_BYTE = 8'hfe;
  localparam logic [7:0]  MARK_BYTE  = 8'hff;

  // Check sequence generators, reflected form, preset to ones
  localparam logic [31:0] CRC16_POLY = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY = 32'hedb8_8320;
  localparam logic [31:0] CRC_PRESET = 32'hffff_ffff;
  localparam logic [1:0]  CRC16_LAST = 2'h1;
  localparam logic [1:0]  CRC32_LAST = 2'h3;

  // Zero insertion after this many ones
  localparam logic [2:0]  ONES_MAX   = 3'h5;

  // Async oversampling divider end counts
  localparam logic [3:0]  DIV_SLOW   = 4'hf;
  localparam logic [3:0]  DIV_FAST   = 4'h7;

  // Serializer counts and frame positions
  localparam logic [3:0]  BYTE_REST  = 4'h7;
  localparam logic [3:0]  POS_AFT7   = 4'h8;
  localparam logic [3:0]  POS_AFT8   = 4'h9;
  localparam logic [7:0]  MASK7      = 8'h7f;
  localparam logic [7:0]  MASK8      = 8'hff;

  // Write strobe bit positions
  localparam int WR_BYTE = 0;
  localparam int WR_WORD = 1;
  localparam int WR_LONG = 2;

  // Transmit status codes
  localparam logic [1:0]  ST_EMPTY   = 2'h0;
  localparam logic [1:0]  ST_CRC     = 2'h1;
  localparam logic [1:0]  ST_ABORT   = 2'h2;
  localparam logic [1:0]  ST_CLOSE   = 2'h3;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_OPEN  = 3'b001,
    H_DATA  = 3'b010,
    H_CRC   = 3'b011,
    H_CLOSE = 3'b100
  } hdlc_st_t;

  // Static configuration levels
  typedef struct packed {
    logic       hdlc;
    logic       wide_check_select;
    logic       irda;
    logic       mark_idle;
    logic       urun_abort;
    logic       fast;
    logic       short_character_select;
    logic       par_en;
    logic [1:0] par_sel;
  } tx_cfg_t;

  // One buffer byte with its tags
  typedef struct packed {
    logic       full;
    logic       eof_tag;
    logic       long_tag;
    logic [7:0] data;
  } slot_t;

  typedef struct packed {
    logic [3:0]  len;
    logic [11:0] bits;
  } frame_t;

endpackage

// ### design/hdlc_async_transmitter.sv
// Async character / HDLC frame transmitter with four-byte ripple buffer
//
// Our own choices: the write port with one strobe per access size and no address.
`timescale 1ns/100ps

module hdlc_async_transmitter (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire hdlc_tx_pkg::tx_cfg_t  cfg_i,
  input  wire logic                  tx_sync_i,
  input  wire logic                  tx_abort_i,
  input  wire logic                  clr_int_i,
  input  wire logic [2:0]            wr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic [3:0]            tag_addr_i,
  input  wire logic [3:0]            tag_long_i,
  output logic      [3:0]            empty_o,
  output logic                       tx_data_o,
  output logic      [1:0]            tx_status_o,
  output logic                       txint_o,
  output logic                       tsync_o
);

  typedef struct packed {
    hdlc_tx_pkg::slot_t [3:0] slot;
    hdlc_tx_pkg::hdlc_st_t    hs;
    logic [11:0]              sh;
    logic [3:0]               cnt;
    logic [3:0]               div;
    logic [2:0]               ones;
    logic                     stf;
    logic                     crcon;
    logic                     abp;
    logic                     busy;
    logic                     pv;
    logic                     txd;
    logic                     tsync;
    logic                     irq;
    logic [31:0]              crc;
    logic [1:0]               ck;
    logic [1:0]               st;
    logic [1:0]               pst;
  } tx_state_t;

  tx_state_t s_r;
  tx_state_t s_nxt;
  logic      tick;
  logic      stuff;
  logic      ld;
  logic      pop;
  logic      purge;

  // One step of the reflected check generator
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic        b,
                                           input logic        w);
    logic [31:0] r;
    r = {1'b0, c[31:1]};
    if (!w) begin
      r[31:15] = '0;
    end
    if (c[0] ^ b) begin
      r = r ^ (w ? hdlc_tx_pkg::CRC32_POLY : hdlc_tx_pkg::CRC16_POLY);
    end
    return r;
  endfunction

  // Pack a written lane into a buffer slot
  function automatic hdlc_tx_pkg::slot_t mk_slot(input logic [7:0] d,
                                                 input logic       a,
                                                 input logic       l);
    return '{full: 1'b1, eof_tag: a, long_tag: l, data: d};
  endfunction

  // Build a whole async character, start bit in bit 0
  function automatic hdlc_tx_pkg::frame_t async_frame(
      input logic [7:0]           d,
      input logic                 a,
      input logic                 l,
      input hdlc_tx_pkg::tx_cfg_t c);
    hdlc_tx_pkg::frame_t f;
    logic [3:0]          p;
    logic                par;
    f.bits    = 12'hfff;
    f.bits[0] = 1'b0;
    f.len     = 4'h0;
    p = c.short_character_select ? hdlc_tx_pkg::POS_AFT7
                                 : hdlc_tx_pkg::POS_AFT8;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || !c.short_character_select) begin
        f.bits[i+1] = d[i];
      end
    end
    par = c.par_sel[1] ? c.par_sel[0]
        : (^(d & (c.short_character_select ? hdlc_tx_pkg::MASK7
                                           : hdlc_tx_pkg::MASK8)))
          ^ c.par_sel[0];
    if (c.par_en) begin
      f.bits[p] = par;
      p = p + 4'h1;
    end
    if (a) begin
      f.bits[p] = 1'b0;
      p = p + 4'h1;
    end else if (l) begin
      f.bits[p] = 1'b1;
      p = p + 4'h1;
    end
    f.len = p;   // Stop bit sits at p, already one
    return f;
  endfunction

  // Bit timing: HDLC runs at the enable rate, async divides it
  assign tick  = tx_sync_i && (cfg_i.hdlc ||
                 s_r.div == (cfg_i.fast ? hdlc_tx_pkg::DIV_FAST
                                        : hdlc_tx_pkg::DIV_SLOW));
  assign stuff = s_r.stf && s_r.ones == hdlc_tx_pkg::ONES_MAX;
  assign ld    = tick && cfg_i.hdlc && s_r.cnt == 4'h0 && !stuff;

  // Next-state logic: serializer, framing, buffer, interrupt
  always_comb begin
    logic [7:0]          u;
    logic                ustf;
    logic                ucrc;
    hdlc_tx_pkg::frame_t f;
    u     = hdlc_tx_pkg::FLAG_BYTE;
    ustf  = 1'b0;
    ucrc  = 1'b0;
    f     = '0;
    s_nxt = s_r;
    pop   = 1'b0;
    purge = 1'b0;
    s_nxt.tsync = 1'b0;
    if (tx_sync_i) begin
      s_nxt.div = (tick || cfg_i.hdlc) ? 4'h0 : s_r.div + 4'h1;
    end
    // Abort is held until the next byte edge; async ignores it
    if (tx_abort_i && cfg_i.hdlc && s_r.hs != hdlc_tx_pkg::H_IDLE) begin
      s_nxt.abp = 1'b1;
    end
    if (tick) begin
      s_nxt.tsync = cfg_i.hdlc || s_r.cnt != 4'h0;
      if (stuff) begin
        s_nxt.txd  = 1'b0;
        s_nxt.ones = 3'h0;
      end else if (s_r.cnt != 4'h0) begin
        s_nxt.txd = s_r.sh[0];
        s_nxt.sh  = {1'b1, s_r.sh[11:1]};
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.stf) begin
          s_nxt.ones = s_r.sh[0] ? s_r.ones + 3'h1 : 3'h0;
        end
        if (s_r.crcon) begin
          s_nxt.crc = crc_step(s_r.crc, s_r.sh[0],
                               cfg_i.wide_check_select);
        end
      end else if (cfg_i.hdlc) begin
        // Byte edge: pick the next whole byte to send
        if (s_r.pv) begin
          s_nxt.st = s_r.pst;
          s_nxt.pv = 1'b0;
        end
        if (s_r.abp) begin
          u          = hdlc_tx_pkg::ABORT_BYTE;
          purge      = 1'b1;
          s_nxt.abp  = 1'b0;
          s_nxt.hs   = hdlc_tx_pkg::H_IDLE;
          s_nxt.pst  = hdlc_tx_pkg::ST_ABORT;
          s_nxt.pv   = 1'b1;
        end else begin
          unique case (s_r.hs)
            hdlc_tx_pkg::H_IDLE: begin
              if (s_r.slot[0].full) begin
                s_nxt.crc = hdlc_tx_pkg::CRC_PRESET;
                s_nxt.hs  = cfg_i.irda ? hdlc_tx_pkg::H_OPEN
                                       : hdlc_tx_pkg::H_DATA;
              end else if (cfg_i.mark_idle) begin
                u = hdlc_tx_pkg::MARK_BYTE;
              end
            end
            hdlc_tx_pkg::H_OPEN: begin
              s_nxt.hs = hdlc_tx_pkg::H_DATA;
            end
            hdlc_tx_pkg::H_DATA: begin
              if (s_r.slot[0].full) begin
                u        = s_r.slot[0].data;
                pop      = 1'b1;
                ustf     = 1'b1;
                ucrc     = 1'b1;
                s_nxt.st = hdlc_tx_pkg::ST_EMPTY;
                s_nxt.ck = 2'h0;
                if (s_r.slot[0].eof_tag) begin
                  s_nxt.hs = hdlc_tx_pkg::H_CRC;
                end else if (s_r.slot[0].long_tag) begin
                  s_nxt.hs = hdlc_tx_pkg::H_CLOSE;
                end
              end else begin
                s_nxt.hs = hdlc_tx_pkg::H_IDLE;
                s_nxt.pv = 1'b1;
                if (cfg_i.urun_abort) begin
                  u         = hdlc_tx_pkg::ABORT_BYTE;
                  s_nxt.pst = hdlc_tx_pkg::ST_ABORT;
                end else begin
                  s_nxt.pst = hdlc_tx_pkg::ST_CLOSE;
                end
              end
            end
            hdlc_tx_pkg::H_CRC: begin
              u        = ~s_r.crc[{s_r.ck, 3'b000} +: 8];
              ustf     = 1'b1;
              s_nxt.ck = s_r.ck + 2'h1;
              if (s_r.ck == (cfg_i.wide_check_select
                             ? hdlc_tx_pkg::CRC32_LAST
                             : hdlc_tx_pkg::CRC16_LAST)) begin
                s_nxt.hs  = hdlc_tx_pkg::H_CLOSE;
                s_nxt.pst = hdlc_tx_pkg::ST_CRC;
                s_nxt.pv  = 1'b1;
              end
            end
            hdlc_tx_pkg::H_CLOSE: begin
              s_nxt.hs  = hdlc_tx_pkg::H_IDLE;
              s_nxt.pst = hdlc_tx_pkg::ST_CLOSE;
              s_nxt.pv  = 1'b1;
            end
            default: begin
              s_nxt.hs = hdlc_tx_pkg::H_IDLE;
            end
          endcase
        end
        // Flags and aborts bypass the zero inserter
        s_nxt.txd   = u[0];
        s_nxt.sh    = {5'h1f, u[7:1]};
        s_nxt.cnt   = hdlc_tx_pkg::BYTE_REST;
        s_nxt.stf   = ustf;
        s_nxt.crcon = ucrc;
        s_nxt.ones  = (ustf && u[0]) ? (s_r.stf ? s_r.ones + 3'h1
                                                : 3'h1) : 3'h0;
        if (ucrc) begin
          s_nxt.crc = crc_step(s_nxt.crc, u[0],
                               cfg_i.wide_check_select);
        end
      end else if (s_r.slot[0].full) begin
        // Async: a whole character leaves the buffer at once
        f = async_frame(s_r.slot[0].data, s_r.slot[0].eof_tag,
                        s_r.slot[0].long_tag, cfg_i);
        pop         = 1'b1;
        s_nxt.txd   = f.bits[0];
        s_nxt.sh    = {1'b1, f.bits[11:1]};
        s_nxt.cnt   = f.len;
        s_nxt.stf   = 1'b0;
        s_nxt.crcon = 1'b0;
        s_nxt.busy  = 1'b1;
        s_nxt.tsync = 1'b1;
      end else begin
        s_nxt.txd  = 1'b1;
        s_nxt.busy = 1'b0;
      end
    end
    if (!cfg_i.hdlc) begin
      s_nxt.st = {s_nxt.busy, 1'b0};
      s_nxt.hs = hdlc_tx_pkg::H_IDLE;
    end
    // Buffer: take, ripple one step right, then accept a write
    if (pop) begin
      s_nxt.slot[0].full = 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      if (!s_nxt.slot[i].full && s_r.slot[i+1].full) begin
        s_nxt.slot[i]        = s_r.slot[i+1];
        s_nxt.slot[i+1].full = 1'b0;
      end
    end
    if (purge) begin
      for (int i = 0; i < 4; i++) begin
        s_nxt.slot[i].full = 1'b0;
      end
    end
    if (wr_i[hdlc_tx_pkg::WR_BYTE]) begin
      s_nxt.slot[3] = mk_slot(wdata_i[7:0], tag_addr_i[0],
                              tag_long_i[0]);
    end else if (wr_i[hdlc_tx_pkg::WR_WORD]) begin
      for (int k = 0; k < 2; k++) begin
        s_nxt.slot[k+2] = mk_slot(wdata_i[8*k +: 8], tag_addr_i[k],
                                  tag_long_i[k]);
      end
    end else if (wr_i[hdlc_tx_pkg::WR_LONG]) begin
      for (int k = 0; k < 4; k++) begin
        s_nxt.slot[k] = mk_slot(wdata_i[8*k +: 8], tag_addr_i[k],
                                tag_long_i[k]);
      end
    end
    // Interrupt: an event in the clearing cycle still sets it
    if (pop || s_nxt.st != s_r.st) begin
      s_nxt.irq = 1'b1;
    end else if (clr_int_i || wr_i != 3'h0) begin
      s_nxt.irq = 1'b0;
    end
  end

  // State register, idle line high after reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r     <= '0;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  for (genvar g = 0; g < 4; g++) begin : g_empty
    assign empty_o[g] = ~s_r.slot[g].full;
  end
  assign tx_data_o   = s_r.txd;
  assign tx_status_o = s_r.st;
  assign txint_o     = s_r.irq;
  assign tsync_o     = s_r.tsync;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence frame_start;
    ld && !s_r.abp && s_r.hs == hdlc_tx_pkg::H_IDLE && s_r.slot[0].full;
  endsequence

  sequence data_edge;
    ld && !s_r.abp && s_r.hs == hdlc_tx_pkg::H_DATA;
  endsequence

  zero_insert_a: assert property (tick && stuff |=> !tx_data_o &&
      s_r.ones == 3'h0 && s_r.cnt == $past(s_r.cnt))
    else $error("missing inserted zero");
  open_flag_a: assert property (frame_start |=>
      s_r.sh[6:0] == hdlc_tx_pkg::FLAG_BYTE[7:1] && !s_r.stf &&
      s_r.crc == hdlc_tx_pkg::CRC_PRESET)
    else $error("opening flag or preset wrong");
  eof_crc_a: assert property (data_edge ##0 (s_r.slot[0].full &&
      s_r.slot[0].eof_tag) |=> s_r.hs == hdlc_tx_pkg::H_CRC)
    else $error("no CRC after end of frame");
  long_close_a: assert property (data_edge ##0 (s_r.slot[0].full &&
      !s_r.slot[0].eof_tag && s_r.slot[0].long_tag)
      |=> s_r.hs == hdlc_tx_pkg::H_CLOSE)
    else $error("no direct closing flag");
  underrun_a: assert property (data_edge ##0 !s_r.slot[0].full
      |=> s_r.hs == hdlc_tx_pkg::H_IDLE && s_r.pv &&
      s_r.pst == ($past(cfg_i.urun_abort) ? hdlc_tx_pkg::ST_ABORT
                                          : hdlc_tx_pkg::ST_CLOSE))
    else $error("underrun handling wrong");
  abort_byte_a: assert property (ld && s_r.abp |=> !tx_data_o &&
      s_r.sh[6:0] == 7'h7f && empty_o == 4'hf &&
      s_r.hs == hdlc_tx_pkg::H_IDLE)
    else $error("abort byte or purge wrong");
  mark_idle_a: assert property (ld && !s_r.abp && cfg_i.mark_idle &&
      s_r.hs == hdlc_tx_pkg::H_IDLE && !s_r.slot[0].full
      |=> tx_data_o && s_r.sh[6:0] == 7'h7f)
    else $error("mark idle not ones");
  whole_byte_a: assert property (ld |=> s_r.cnt ==
      hdlc_tx_pkg::BYTE_REST)
    else $error("partial byte sent");
  two_flags_a: assert property (frame_start ##0 cfg_i.irda |=>
      s_r.hs == hdlc_tx_pkg::H_OPEN)
    else $error("second opening flag missing");
  int_set_a: assert property (pop |=> txint_o)
    else $error("interrupt not set on removal");
  bit_strobe_a: assert property (tsync_o |-> $past(tick))
    else $error("bit strobe without bit enable");

endmodule

// ### bench/tx_loader.sv
// Loader model that feeds the transmit buffer from a queue of writes
`timescale 1ns/100ps
module tx_loader (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  empty_i,
  output logic      [2:0]  wr_o,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  tag_addr_o,
  output logic      [3:0]  tag_long_o
);
  logic [41:0] q[$];
  int          gap_cyc = 0;
  int          hold    = 0;
  logic [3:0]  need;
  logic [41:0] it;

  // Queue one write: kind 0 byte, 1 word, 2 long
  task automatic push(input logic [1:0] k, input logic [31:0] d,
                      input logic [3:0] ta, input logic [3:0] tl);
    q.push_back({k, d, ta, tl});
  endtask

  initial begin
    wr_o       = 3'h0;
    wdata_o    = 32'h0;
    tag_addr_o = 4'h0;
    tag_long_o = 4'h0;
  end

  // Write only into empty slots; idle data lines flip so that a stale
  // value is never mistaken for a fresh one
  always @(posedge clk_i) begin
    it = (q.size() > 0) ? q[0] : 42'h0;
    need = (it[41:40] == 2'h0) ? 4'h8 : (it[41:40] == 2'h1) ? 4'hc : 4'hf;
    if (rst_n_i && hold == 0 && q.size() > 0 && (empty_i & need) == need) begin
      wr_o       <= 3'h1 << it[41:40];
      wdata_o    <= it[39:8];
      tag_addr_o <= it[7:4];
      tag_long_o <= it[3:0];
      hold       <= gap_cyc + 1; // Empty flags lag our own write a cycle
      void'(q.pop_front());
    end else begin
      wr_o       <= 3'h0;
      wdata_o    <= ~wdata_o;
      tag_addr_o <= ~tag_addr_o;
      tag_long_o <= ~tag_long_o;
      if (hold > 0) hold <= hold - 1;
    end
  end
endmodule

// ### bench/tb_hdlc_async_transmitter.sv
// Self-checking bench for the async / HDLC serial transmitter
`timescale 1ns/100ps
module tb_hdlc_async_transmitter;
  logic                 clk_i;
  logic                 rst_n_i;
  hdlc_tx_pkg::tx_cfg_t cfg_i;
  logic                 tx_sync_i;
  logic                 tx_abort_i;
  logic                 clr_int_i;
  logic [2:0]           wr_i;
  logic [31:0]          wdata_i;
  logic [3:0]           tag_addr_i;
  logic [3:0]           tag_long_i;
  logic [3:0]           empty_o;
  logic                 tx_data_o;
  logic [1:0]           tx_status_o;
  logic                 txint_o;
  logic                 tsync_o;
  int                   err_total  = 0;
  int                   n_compared = 0;
  int                   cyc        = 0;
  logic [31:0]          lfsr       = 32'h4108b850;
  logic [31:0]          sync_sr    = 32'h4108b850;
  bit                   bq[$];
  bit                   ex[$];
  bit                   pl[$];

  hdlc_async_transmitter u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cfg_i(cfg_i), .tx_sync_i(tx_sync_i), .tx_abort_i(tx_abort_i),
    .clr_int_i(clr_int_i), .wr_i(wr_i), .wdata_i(wdata_i),
    .tag_addr_i(tag_addr_i), .tag_long_i(tag_long_i), .empty_o(empty_o),
    .tx_data_o(tx_data_o), .tx_status_o(tx_status_o), .txint_o(txint_o),
    .tsync_o(tsync_o));
  tx_loader u_ldr (.clk_i(clk_i), .rst_n_i(rst_n_i), .empty_i(empty_o),
    .wr_o(wr_i), .wdata_o(wdata_i), .tag_addr_o(tag_addr_i),
    .tag_long_o(tag_long_i));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] rnd();
    lfsr = nxt(lfsr);
    return lfsr;
  endfunction

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put_bits(input logic [7:0] b, input int n);
    for (int k = 0; k < n; k++) ex.push_back(b[k]);
  endtask

  // Look for the expected bits as one unbroken run in the captured line
  task automatic match(output bit ok);
    ok = 1'b0;
    for (int s = 0; s + ex.size() <= bq.size(); s++) begin
      if (!ok) begin
        ok = 1'b1;
        foreach (ex[k]) if (bq[s + k] != ex[k]) ok = 1'b0;
      end
    end
  endtask

  task automatic wait_st(input logic [1:0] code, input int lim);
    for (int i = 0; i < lim && tx_status_o !== code; i++) @(posedge clk_i);
    chk(tx_status_o, code);
  endtask

  // One async character pair; parity mode and tags follow the index
  task automatic async_char(input int i);
    logic [31:0] r;
    logic [7:0]  d;
    logic        ta;
    logic        tl;
    bit          ok;
    r = rnd();
    @(posedge clk_i);
    cfg_i <= {1'b0, r[9:8], 2'b00, r[11], r[10], ~i[2], i[1:0]};
    u_ldr.gap_cyc = i * 7;
    @(negedge clk_i);
    bq.delete();
    ex.delete();
    for (int c = 0; c < 2; c++) begin
      d = (c == 0) ? r[7:0] : r[23:16];
      ta = (c == 0) && (i % 3 == 1);
      tl = (i % 3 == 2) || (i == 7);
      u_ldr.push(2'h0, {24'h0, d}, {3'h0, ta}, {3'h0, tl});
      d = d & (r[10] ? 8'h7f : 8'hff);
      ex.push_back(1'b0);
      put_bits(d, r[10] ? 7 : 8);
      if (!i[2]) ex.push_back(i[1] ? i[0] : (^d) ^ i[0]);
      if (ta || tl) ex.push_back(!ta);
      ex.push_back(1'b1);
    end
    if (i == 3) begin
      repeat (30) @(posedge clk_i);
      tx_abort_i <= 1'b1;
      @(posedge clk_i);
      tx_abort_i <= 1'b0;
    end
    for (int k = 0; k < 4000 && bq.size() < ex.size(); k++) @(posedge clk_i);
    wait_st(2'h0, 300);
    chk(bq.size(), ex.size());
    match(ok);
    chk(ok, 1'b1);
  endtask

  // One HDLC frame; endk: 0 check end, 1 long-stop end, 2/3 underrun
  task automatic frame(input int n, input int lw, input int endk,
                       input logic wide, input logic irda, input logic mark);
    logic [31:0] crc;
    logic [31:0] r;
    logic [31:0] d;
    logic [7:0]  b;
    logic [3:0]  ta;
    logic [3:0]  tl;
    int          w;
    int          k;
    bit          ok;
    @(posedge clk_i);
    cfg_i <= {1'b1, wide, irda, mark, endk == 2, 5'h00};
    u_ldr.gap_cyc = 0;
    @(negedge clk_i);
    bq.delete();
    ex.delete();
    pl.delete();
    // Let a whole idle byte go out before the frame is queued
    repeat (60) @(posedge clk_i);
    @(negedge clk_i);
    put_bits(mark ? 8'hff : hdlc_tx_pkg::FLAG_BYTE, 8);
    put_bits(hdlc_tx_pkg::FLAG_BYTE, 8);
    if (irda) put_bits(hdlc_tx_pkg::FLAG_BYTE, 8);
    crc = wide ? 32'hffff_ffff : 32'h0000_ffff;
    w = 1 << lw;
    d = 32'h0;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      b = (i == 1) ? 8'hff : r[7:0];
      d[8 * (i % w) +: 8] = b;
      for (k = 0; k < 8; k++) begin
        pl.push_back(b[k]);
        crc = {1'b0, crc[31:1]} ^ (!(crc[0] ^ b[k]) ? 32'h0 :
              wide ? hdlc_tx_pkg::CRC32_POLY : hdlc_tx_pkg::CRC16_POLY);
      end
      ta = (i == n - 1 && endk == 0) ? 4'h1 << (w - 1) : 4'h0;
      tl = (i == n - 1 && endk == 1) ? 4'h1 << (w - 1) : 4'h0;
      if (i % w == w - 1) u_ldr.push(lw[1:0], d, ta, tl);
    end
    if (endk == 0) for (k = 0; k < (wide ? 32 : 16); k++) pl.push_back(~crc[k]);
    k = 0;
    foreach (pl[j]) begin
      ex.push_back(pl[j]);
      k = pl[j] ? k + 1 : 0;
      if (k == 5) begin
        ex.push_back(1'b0);
        k = 0;
      end
    end
    put_bits(endk == 2 ? 8'hfe : hdlc_tx_pkg::FLAG_BYTE, 8);
    wait_st(2'h0, 400);
    if (endk == 0) wait_st(2'h1, 3000);
    wait_st(endk == 2 ? 2'h2 : 2'h3, 3000);
    @(posedge clk_i);
    chk(txint_o, 1'b1);
    match(ok);
    chk(ok, 1'b1);
    clr_int_i <= 1'b1;
    @(posedge clk_i);
    clr_int_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(txint_o, 1'b0);
  endtask

  // Abort in mid-frame with a full buffer behind it
  task automatic abort_run();
    bit ok;
    @(posedge clk_i);
    cfg_i <= {4'b1001, 6'h00};
    for (int i = 0; i < 9; i++) u_ldr.push(2'h0, rnd(), 4'h0, 4'h0);
    wait_st(2'h0, 400);
    repeat (20) @(posedge clk_i);
    u_ldr.q.delete();
    tx_abort_i <= 1'b1;
    @(posedge clk_i);
    tx_abort_i <= 1'b0;
    @(negedge clk_i);
    bq.delete();
    ex.delete();
    put_bits(hdlc_tx_pkg::ABORT_BYTE, 8);
    put_bits(8'hff, 8);
    wait_st(2'h2, 400);
    chk(empty_o, 4'hf);
    repeat (80) @(posedge clk_i);
    match(ok);
    chk(ok, 1'b1);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Random bit-rate enable; serial capture at each bit-start strobe
  always @(posedge clk_i) begin
    sync_sr <= nxt(sync_sr);
    tx_sync_i <= sync_sr[5];
    cyc <= cyc + 1;
    if (tsync_o === 1'b1) bq.push_back(tx_data_o);
    if (rst_n_i && cfg_i.hdlc === 1'b0 && tsync_o === 1'b1)
      chk(tx_status_o, 2'h2);
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    cfg_i = '0;
    tx_sync_i = 1'b0;
    tx_abort_i = 1'b0;
    clr_int_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(empty_o, 4'hf);
    chk({tx_status_o, txint_o}, 3'h0);
    for (int i = 0; i < 8; i++) async_char(i);
    frame(5, 0, 0, 1'b0, 1'b0, 1'b0);
    frame(4, 2, 0, 1'b1, 1'b0, 1'b1);
    frame(6, 1, 0, 1'b0, 1'b1, 1'b1);
    frame(3, 0, 1, 1'b0, 1'b0, 1'b1);
    frame(2, 0, 2, 1'b1, 1'b0, 1'b1);
    frame(2, 0, 3, 1'b0, 1'b0, 1'b0);
    abort_run();
    close_out();
  end
endmodule
